/* File: test/flpc_host_model.sv */
// host-side avalon-mm master model for the fifo level/power registers
`timescale 1ns/1ps
module flpc_host_model (
   input wire logic clock_in,
   input wire logic waitrequest_in,
   input wire logic [31:0] readdata_in,
   output logic [7:0] address_out,
   output logic read_out,
   output logic write_out,
   output logic [31:0] writedata_out,
   output logic [3:0] byteenable_out
);
   initial begin
      address_out = 8'h00;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'h5A5A_5A5A;
      byteenable_out = 4'hF;
   end
   // entered just after a rising edge; leaves one idle cycle so requests never abut
   task automatic xfer(input logic is_wr, input logic [7:0] adr, input logic [31:0] wd,
                       input logic [3:0] ben, output logic [31:0] rd);
      address_out <= adr;
      writedata_out <= wd;
      byteenable_out <= ben;
      read_out <= !is_wr;
      write_out <= is_wr;
      // only the bench watchdog ends a wait that never gets an answer
      do begin
         @(posedge clock_in);
      end while (waitrequest_in !== 1'b0);
      rd = readdata_in;
      read_out <= 1'b0;
      write_out <= 1'b0;
      // released data must not keep its last value
      writedata_out <= ~wd;
      @(posedge clock_in);
   endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the fifo level/power register block
`timescale 1ns/1ps
module tb_top;
   localparam int PHY_C = 20;
   localparam int PULSE_C = 30;
   logic clock_in = 1'b0;
   logic rst_n_in;
   logic [11:0] ev_v;
   logic [15:0] frame_len;
   logic [7:0] address;
   logic rd_s, wr_s, waitreq, irq;
   logic [31:0] wdata, rdata;
   logic [3:0] be;
   logic [1:0] state;
   logic phy_reset_request, pev_int, pev_out, pev_oe;
   int n_fail = 0;
   int comparisons = 0;
   int n;
   always #10 clock_in = ~clock_in;
   flpc_top #(.PHY_RESET_CYCLES(PHY_C), .PULSE_CYCLES(PULSE_C)) dut_u (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .soft_reset_in(ev_v[11]),
      .address_in(address), .read_in(rd_s), .write_in(wr_s), .writedata_in(wdata),
      .byteenable_in(be), .readdata_out(rdata), .waitrequest_out(waitreq),
      .rx_status_push_in(ev_v[0]), .rx_status_pop_in(ev_v[1]), .rx_data_push_in(ev_v[2]),
      .rx_frame_len_in(frame_len), .rx_data_pop_in(ev_v[3]), .tx_status_push_in(ev_v[4]),
      .tx_status_pop_in(ev_v[5]), .tx_data_push_in(ev_v[6]), .tx_data_drain_in(ev_v[7]),
      .byte_test_write_in(ev_v[8]), .wake_frame_event_in(ev_v[9]),
      .energy_detect_event_in(ev_v[10]), .power_state_out(state), .phy_reset_out(phy_reset_request),
      .power_event_interrupt_out(pev_int), .power_event_out(pev_out),
      .power_event_oe_out(pev_oe));
   flpc_host_model host_u (
      .clock_in(clock_in), .waitrequest_in(waitreq), .readdata_in(rdata),
      .address_out(address), .read_out(rd_s), .write_out(wr_s), .writedata_out(wdata),
      .byteenable_out(be));
   task automatic report_and_stop();
      if (n_fail == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] ben = 4'hF);
      logic [31:0] dummy;
      host_u.xfer(1'b1, a, v, ben, dummy);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
      logic [31:0] d;
      host_u.xfer(1'b0, a, 32'h0000_0000, 4'hF, d);
      check(nm, d & m, exp);
   endtask
   task automatic pulse(input int b, input int cnt);
      repeat (cnt) begin
         ev_v[b] <= 1'b1;
         @(posedge clock_in);
         ev_v[b] <= 1'b0;
         @(posedge clock_in);
      end
   endtask
   // interrupt is a one-cycle pulse, so two edges are looked at
   task automatic fire(input int b, output logic hit);
      ev_v[b] <= 1'b1;
      @(posedge clock_in);
      ev_v[b] <= 1'b0;
      @(posedge clock_in);
      hit = pev_int;
      @(posedge clock_in);
      hit = hit | pev_int;
   endtask
   initial begin
      repeat (20000) @(posedge clock_in);
      n_fail++;
      report_and_stop();
   end
   initial begin
      ev_v = 12'h000;
      frame_len = 16'h0000;
      rst_n_in = 1'b0;
      repeat (6) @(posedge clock_in);
      rst_n_in <= 1'b1;
      @(posedge clock_in);
      rdc("ready_early", 8'h84, 32'hFFFF_FFFF, 32'h0000_0000);
      repeat (20) @(posedge clock_in);
      rdc("power_reset", 8'h84, 32'hFFFF_FFFF, 32'h0000_0001);
      rdc("rx_reset", 8'h7C, 32'hFFFF_FFFF, 32'h0000_0000);
      rdc("tx_reset", 8'h80, 32'hFFFF_FFFF, 32'h0000_1200);
      rdc("unmapped", 8'h88, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(8'h7C, 32'hFFFF_FFFF);
      rdc("rx_ro", 8'h7C, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(8'h84, 32'hFFFF_C880);
      rdc("power_rsvd", 8'h84, 32'hFFFF_FFFF, 32'h0000_0001);
      pulse(0, 3);
      pulse(1, 1);
      frame_len <= 16'h0005;
      pulse(2, 1);
      frame_len <= 16'h0008;
      pulse(2, 1);
      pulse(3, 1);
      pulse(4, 2);
      // pushes stay well inside the reported free space
      pulse(6, 2);
      pulse(7, 1);
      rdc("rx_level", 8'h7C, 32'hFFFF_FFFF, 32'h0002_000C);
      rdc("tx_level", 8'h80, 32'hFFFF_FFFF, 32'h0002_11FC);
      wr(8'h84, 32'h0000_0200);
      fire(9, irq);
      check("wake_irq_no_oe", {31'h0, irq}, 32'h1);
      check("oe_gated", {31'h0, pev_oe}, 32'h0);
      wr(8'h84, 32'h0000_024E);
      rdc("power_cfg", 8'h84, 32'hFFFF_FFFF, 32'h0000_024F);
      fire(9, irq);
      check("wake_irq", {31'h0, irq}, 32'h1);
      n = 0;
      while (pev_out !== 1'b1 && n < 10) begin
         @(posedge clock_in);
         n++;
      end
      check("pin_pushpull", {30'h0, pev_out, pev_oe}, 32'h3);
      n = 0;
      while (pev_out === 1'b1 && n < 200) begin
         @(posedge clock_in);
         n++;
      end
      check("pulse_len", {31'h0, n >= PULSE_C && n <= PULSE_C + 2}, 32'h1);
      pulse(11, 1);
      rdc("soft_reset", 8'h84, 32'hFFFF_FFFF, 32'h0000_0045);
      wr(8'h84, 32'h0000_0102);
      fire(10, irq);
      check("ed_irq", {31'h0, irq}, 32'h1);
      repeat (3) @(posedge clock_in);
      check("pin_open_drain", {30'h0, pev_out, pev_oe}, 32'h1);
      wr(8'h84, 32'h0000_0002);
      repeat (3) @(posedge clock_in);
      check("pin_cleared", {31'h0, pev_oe}, 32'h0);
      fire(10, irq);
      check("ed_disabled", {31'h0, irq}, 32'h0);
      wr(8'h84, 32'h0000_0400);
      // the pin copy lands one edge after the write takes effect
      @(posedge clock_in);
      check("phy_start", {31'h0, phy_reset_request}, 32'h1);
      rdc("phy_bit", 8'h84, 32'h0000_0400, 32'h0000_0400);
      wr(8'h84, 32'h0000_0000);
      rdc("phy_locked", 8'h84, 32'h0000_0400, 32'h0000_0400);
      n = 0;
      while (phy_reset_request === 1'b1 && n < 200) begin
         @(posedge clock_in);
         n++;
      end
      // about ten cycles already passed in the accesses above
      check("phy_len", {31'h0, n + 10 >= PHY_C && n < 200}, 32'h1);
      rdc("phy_clear", 8'h84, 32'h0000_0400, 32'h0000_0000);
      for (int st = 1; st < 3; st++) begin
         wr(8'h84, 32'(st) << 12);
         repeat (3) @(posedge clock_in);
         check("state_set", {30'h0, state}, 32'(st));
         rdc("state_read", 8'h84, 32'h0000_3000, 32'(st) << 12);
         pulse(8, 1);
         repeat (3) @(posedge clock_in);
         check("state_wake", {30'h0, state}, 32'h0);
         repeat (20) @(posedge clock_in);
         wr(8'h84, 32'h0000_0300);
         rdc("wake_no_write", 8'h84, 32'h0000_0301, 32'h0000_0001);
      end
      wr(8'h84, 32'h0000_3000);
      repeat (3) @(posedge clock_in);
      check("state_reserved", {30'h0, state}, 32'h0);
      // upper lane disabled: enables in the data must not land
      wr(8'h84, 32'h0000_034E, 4'h1);
      rdc("byte_lane", 8'h84, 32'hFFFF_FFFF, 32'h0000_004F);
      wr(8'h84, 32'h0000_0040, 4'h1);
      repeat (3) @(posedge clock_in);
      check("pin_idle_low_pol", {30'h0, pev_out, pev_oe}, 32'h3);
      report_and_stop();
   end
endmodule

/* File: verilog/flpc_pkg.sv */
// types shared by the fifo level/power block
package flpc_pkg;
   typedef enum logic [1:0] {FLPC_D0, FLPC_D1, FLPC_D2, FLPC_DRES} flpc_state_t;
   typedef enum {FLPC_IDLE, FLPC_ANSWER} flpc_bus_t;
endpackage

/* File: verilog/flpc_regs.svh */
// register offsets, field positions, reset values and timing for the fifo level/power block
// How it works
// RULE_01 - rx level register bits 23-16 show used rx status dwords, reset zero
// RULE_02 - bits 15-0 show rx data bytes used; frames add length rounded to dwords
// RULE_03 - tx level register bits 23-16 show used tx status dwords, reset zero
// RULE_04 - tx level bits 15-0 show free tx data bytes, reset 1200h
// RULE_05 - host never pushes more tx bytes than the free count shows
// RULE_06 - power register stays readable in every reduced power state
// RULE_07 - after reset or wake, writes are ignored until one read happens
// RULE_08 - power state bits 13-12 self clear, reset 00, 01 D1, 10 D2
// RULE_09 - byte-order test write in reduced power wakes the device
// RULE_10 - host writes only the byte-order test register while not ready
// RULE_11 - writing 1 to bit 10 resets the phy at least 100us, then clears
// RULE_12 - writes to the phy reset bit are ignored while it is set
// RULE_13 - wake frame with enable drives power event pin if output enabled
// RULE_14 - wake frame with enable raises the internal power event interrupt
// RULE_15 - energy detect with enable drives pin if enabled, always interrupt
// RULE_16 - bit 6: 0 open drain active low, 1 push-pull; kept over soft reset
// RULE_17 - ready bit 0 reads 1 only once the device has stabilised
// RULE_18 - pulse select makes the pin pulse 50ms, else it stays asserted
// RULE_19 - output enable gates only the pin, never the interrupt
// RULE_20 - reserved bits read zero and ignore writes
// RULE_21 - counts update the cycle after each push or pop
`ifndef FLPC_REGS_SVH
`define FLPC_REGS_SVH
`define FLPC_RX_LEVEL_OFS 8'h7C
`define FLPC_TX_LEVEL_OFS 8'h80
`define FLPC_POWER_OFS 8'h84
`define FLPC_RX_STATUS_RST 8'h00
`define FLPC_RX_DATA_RST 16'h0000
`define FLPC_TX_STATUS_RST 8'h00
`define FLPC_TX_FREE_RST 16'h1200
`define FLPC_DWORD_BYTES 16'h0004
`define FLPC_BIT_STATE_LO 12
`define FLPC_BIT_PHY_RESET_REQUEST 10
`define FLPC_BIT_WAKE_EN 9
`define FLPC_BIT_ENERGY_DETECT_ENABLE 8
`define FLPC_BIT_BUF_TYPE 6
`define FLPC_BIT_PULSE 3
`define FLPC_BIT_POL 2
`define FLPC_BIT_OUT_EN 1
`define FLPC_BIT_READY 0
`define FLPC_CLK_MHZ 50
`define FLPC_PHY_RESET_REQUEST_US 100
`define FLPC_PULSE_MS 50
`define FLPC_US_PER_MS 1000
`define FLPC_READY_CYCLES 8'h10
`endif

/* File: verilog/flpc_top.sv */
// fifo level and power control registers behind an avalon-mm slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "flpc_regs.svh"
module flpc_top
   import flpc_pkg::*;
#(
   parameter int PHY_RESET_CYCLES = `FLPC_PHY_RESET_REQUEST_US * `FLPC_CLK_MHZ,
   parameter int PULSE_CYCLES = `FLPC_PULSE_MS * `FLPC_US_PER_MS * `FLPC_CLK_MHZ
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic soft_reset_in,
   input wire logic [7:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic rx_status_push_in,
   input wire logic rx_status_pop_in,
   input wire logic rx_data_push_in,
   input wire logic [15:0] rx_frame_len_in,
   input wire logic rx_data_pop_in,
   input wire logic tx_status_push_in,
   input wire logic tx_status_pop_in,
   input wire logic tx_data_push_in,
   input wire logic tx_data_drain_in,
   input wire logic byte_test_write_in,
   input wire logic wake_frame_event_in,
   input wire logic energy_detect_event_in,
   output logic [1:0] power_state_out,
   output logic phy_reset_out,
   output logic power_event_interrupt_out,
   output logic power_event_out,
   output logic power_event_oe_out
);
   flpc_bus_t bus_ff;
   logic [7:0] rx_status_used_dwords_ff;
   logic [15:0] rx_data_used_bytes_ff;
   logic [7:0] tx_status_used_dwords_ff;
   logic [15:0] tx_data_free_bytes_ff;
   flpc_state_t power_state_select_ff;
   logic phy_reset_request_ff;
   logic [31:0] phy_cnt_ff;
   logic wake_frame_enable_ff;
   logic energy_detect_enable_ff;
   logic power_event_buffer_type_ff;
   logic power_event_pulse_select_ff;
   logic power_event_polarity_ff;
   logic power_event_output_enable_ff;
   logic ready_ff;
   logic [7:0] ready_cnt_ff;
   logic read_seen_ff;
   logic event_hold_ff;
   logic [31:0] pulse_cnt_ff;
   logic [15:0] rx_len_dw;
   logic do_write, do_read, pw_write, trigger, pin_active;
   logic [31:0] nxt_readdata;
   logic [31:0] power_word;

   // the access completes at the edge where waitrequest is seen low
   assign do_write = write_in && (bus_ff == FLPC_ANSWER);
   assign do_read = read_in && (bus_ff == FLPC_ANSWER);
   // writes before the first read are dropped so a waking bus cannot corrupt state
   assign pw_write = do_write && read_seen_ff && (address_in == `FLPC_POWER_OFS); // [RULE_07]
   assign rx_len_dw = (rx_frame_len_in + 16'h0003) & 16'hFFFC; // [RULE_02]
   assign trigger = (wake_frame_enable_ff && wake_frame_event_in) // [RULE_14]
      || (energy_detect_enable_ff && energy_detect_event_in); // [RULE_15]
   assign pin_active = event_hold_ff && power_event_output_enable_ff; // [RULE_19]

   always_comb begin
      power_word = 32'h0000_0000; // [RULE_20]
      power_word[`FLPC_BIT_STATE_LO+1:`FLPC_BIT_STATE_LO] = power_state_select_ff;
      power_word[`FLPC_BIT_PHY_RESET_REQUEST] = phy_reset_request_ff;
      power_word[`FLPC_BIT_WAKE_EN] = wake_frame_enable_ff;
      power_word[`FLPC_BIT_ENERGY_DETECT_ENABLE] = energy_detect_enable_ff;
      power_word[`FLPC_BIT_BUF_TYPE] = power_event_buffer_type_ff;
      power_word[`FLPC_BIT_PULSE] = power_event_pulse_select_ff;
      power_word[`FLPC_BIT_POL] = power_event_polarity_ff;
      power_word[`FLPC_BIT_OUT_EN] = power_event_output_enable_ff;
      power_word[`FLPC_BIT_READY] = ready_ff; // [RULE_17]
      case (address_in)
         `FLPC_RX_LEVEL_OFS: nxt_readdata = {8'h00, rx_status_used_dwords_ff,
            rx_data_used_bytes_ff}; // [RULE_01] [RULE_02]
         `FLPC_TX_LEVEL_OFS: nxt_readdata = {8'h00, tx_status_used_dwords_ff,
            tx_data_free_bytes_ff}; // [RULE_03] [RULE_04]
         `FLPC_POWER_OFS: nxt_readdata = power_word; // [RULE_06]
         default: nxt_readdata = 32'h0000_0000;
      endcase
   end

   // one wait state on every access; readable in any power state
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_ff <= FLPC_IDLE;
         waitrequest_out <= 1'b1;
         readdata_out <= 32'h0000_0000;
      end else begin
         case (bus_ff)
            FLPC_IDLE: begin
               if (read_in || write_in) begin
                  bus_ff <= FLPC_ANSWER;
                  waitrequest_out <= 1'b0;
                  readdata_out <= read_in ? nxt_readdata : 32'h0000_0000; // [RULE_06]
               end
            end
            FLPC_ANSWER: begin
               bus_ff <= FLPC_IDLE;
               waitrequest_out <= 1'b1;
            end
            default: begin
               bus_ff <= FLPC_IDLE;
               waitrequest_out <= 1'b1;
            end
         endcase
      end
   end

   // fifo level counters; the host keeps pushes within the free count
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_status_used_dwords_ff <= `FLPC_RX_STATUS_RST;
         rx_data_used_bytes_ff <= `FLPC_RX_DATA_RST;
         tx_status_used_dwords_ff <= `FLPC_TX_STATUS_RST;
         tx_data_free_bytes_ff <= `FLPC_TX_FREE_RST;
      end else begin
         rx_status_used_dwords_ff <= rx_status_used_dwords_ff
            + {7'h00, rx_status_push_in} - {7'h00, rx_status_pop_in}; // [RULE_01] [RULE_21]
         rx_data_used_bytes_ff <= rx_data_used_bytes_ff
            + (rx_data_push_in ? rx_len_dw : 16'h0000)
            - (rx_data_pop_in ? `FLPC_DWORD_BYTES : 16'h0000); // [RULE_02] [RULE_21]
         tx_status_used_dwords_ff <= tx_status_used_dwords_ff
            + {7'h00, tx_status_push_in} - {7'h00, tx_status_pop_in}; // [RULE_03] [RULE_21]
         tx_data_free_bytes_ff <= tx_data_free_bytes_ff // [RULE_05]
            - (tx_data_push_in ? `FLPC_DWORD_BYTES : 16'h0000)
            + (tx_data_drain_in ? `FLPC_DWORD_BYTES : 16'h0000); // [RULE_04] [RULE_21]
      end
   end

   // power state, ready and first-read tracking
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_state_select_ff <= FLPC_D0;
         ready_ff <= 1'b0;
         ready_cnt_ff <= 8'h00;
         read_seen_ff <= 1'b0;
      end else if (power_state_select_ff != FLPC_D0 && byte_test_write_in) begin
         power_state_select_ff <= FLPC_D0; // [RULE_08] [RULE_09]
         ready_ff <= 1'b0;
         ready_cnt_ff <= 8'h00;
         read_seen_ff <= 1'b0; // [RULE_07]
      end else begin
         if (!ready_ff) begin
            ready_cnt_ff <= ready_cnt_ff + 8'h01;
            ready_ff <= (ready_cnt_ff == `FLPC_READY_CYCLES - 8'h01); // [RULE_17]
         end
         if (do_read) begin
            read_seen_ff <= 1'b1; // [RULE_07]
         end
         // the reserved encoding is refused rather than stored
         if (pw_write && byteenable_in[1] && ready_ff
             && writedata_in[`FLPC_BIT_STATE_LO+1:`FLPC_BIT_STATE_LO] != 2'b11) begin
            power_state_select_ff <= flpc_state_t'(
               writedata_in[`FLPC_BIT_STATE_LO+1:`FLPC_BIT_STATE_LO]); // [RULE_08]
         end
      end
   end

   // phy reset held for the full time, writes ignored while it runs
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phy_reset_request_ff <= 1'b0;
         phy_cnt_ff <= 32'h0000_0000;
      end else if (phy_reset_request_ff) begin
         phy_cnt_ff <= phy_cnt_ff + 32'h0000_0001;
         if (phy_cnt_ff == 32'(PHY_RESET_CYCLES - 1)) begin
            phy_reset_request_ff <= 1'b0; // [RULE_11]
         end
      end else if (pw_write && byteenable_in[1] && writedata_in[`FLPC_BIT_PHY_RESET_REQUEST]) begin
         phy_reset_request_ff <= 1'b1; // [RULE_11] [RULE_12]
         phy_cnt_ff <= 32'h0000_0000;
      end
   end

   // control bits; buffer type and polarity survive soft reset
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_frame_enable_ff <= 1'b0;
         energy_detect_enable_ff <= 1'b0;
         power_event_buffer_type_ff <= 1'b0;
         power_event_pulse_select_ff <= 1'b0;
         power_event_polarity_ff <= 1'b0;
         power_event_output_enable_ff <= 1'b0;
      end else if (soft_reset_in) begin
         wake_frame_enable_ff <= 1'b0;
         energy_detect_enable_ff <= 1'b0;
         power_event_pulse_select_ff <= 1'b0;
         power_event_output_enable_ff <= 1'b0; // [RULE_16]
      end else if (pw_write) begin
         if (byteenable_in[1]) begin
            wake_frame_enable_ff <= writedata_in[`FLPC_BIT_WAKE_EN];
            energy_detect_enable_ff <= writedata_in[`FLPC_BIT_ENERGY_DETECT_ENABLE];
         end
         if (byteenable_in[0]) begin
            power_event_buffer_type_ff <= writedata_in[`FLPC_BIT_BUF_TYPE]; // [RULE_16]
            power_event_pulse_select_ff <= writedata_in[`FLPC_BIT_PULSE];
            power_event_polarity_ff <= writedata_in[`FLPC_BIT_POL];
            power_event_output_enable_ff <= writedata_in[`FLPC_BIT_OUT_EN];
         end
      end
   end

   // event latch: static until the enables drop, or a timed pulse
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         event_hold_ff <= 1'b0;
         pulse_cnt_ff <= 32'h0000_0000;
         power_event_interrupt_out <= 1'b0;
      end else begin
         power_event_interrupt_out <= trigger; // [RULE_14] [RULE_15] [RULE_19]
         if (trigger) begin
            event_hold_ff <= 1'b1; // [RULE_13] [RULE_15]
            pulse_cnt_ff <= 32'h0000_0000;
         end else if (!wake_frame_enable_ff && !energy_detect_enable_ff) begin
            event_hold_ff <= 1'b0;
         end else if (event_hold_ff && power_event_pulse_select_ff) begin
            pulse_cnt_ff <= pulse_cnt_ff + 32'h0000_0001;
            if (pulse_cnt_ff == 32'(PULSE_CYCLES - 1)) begin
               event_hold_ff <= 1'b0; // [RULE_18]
            end
         end
      end
   end

   // open drain only ever pulls low; push-pull follows the polarity
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_event_out <= 1'b0;
         power_event_oe_out <= 1'b0;
         power_state_out <= 2'b00;
         phy_reset_out <= 1'b0;
      end else begin
         power_state_out <= power_state_select_ff;
         phy_reset_out <= phy_reset_request_ff;
         if (power_event_buffer_type_ff) begin
            power_event_oe_out <= 1'b1;
            power_event_out <= pin_active ~^ power_event_polarity_ff; // [RULE_16]
         end else begin
            power_event_oe_out <= pin_active; // [RULE_13] [RULE_16]
            power_event_out <= 1'b0;
         end
      end
   end

   sequence s_access_starts;
      (read_in || write_in) && bus_ff == FLPC_IDLE;
   endsequence
   sequence s_answer;
      !waitrequest_out ##1 waitrequest_out;
   endsequence

   AST_BUS_ONE_WAIT: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_06]
      s_access_starts |=> s_answer) else $error("answer not one cycle after request");
   AST_WRITE_NEEDS_READ: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_07]
      !read_seen_ff && do_write && !soft_reset_in |=> $stable(wake_frame_enable_ff))
      else $error("write took effect before first read");
   AST_RESERVED_STATE: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_08]
      power_state_select_ff != FLPC_DRES) else $error("reserved power state stored");
   AST_WAKE_ON_TEST: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_09]
      power_state_select_ff != FLPC_D0 && byte_test_write_in
      |=> power_state_select_ff == FLPC_D0 && !ready_ff) else $error("no wake");
   AST_PHY_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_11]
      $rose(phy_reset_request_ff) |-> phy_reset_request_ff [*8])
      else $error("phy reset released early");
   AST_PHY_ENDS: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_11]
      phy_reset_request_ff && phy_cnt_ff == 32'(PHY_RESET_CYCLES - 1)
      |=> !phy_reset_request_ff) else $error("phy reset not cleared");
   AST_PHY_IGNORE: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_12]
      phy_reset_request_ff && pw_write |=> phy_cnt_ff == $past(phy_cnt_ff) + 32'h0000_0001)
      else $error("phy reset restarted by write");
   AST_IRQ_FOLLOWS: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_14]
      wake_frame_event_in && wake_frame_enable_ff |=> power_event_interrupt_out)
      else $error("interrupt missing");
   AST_OD_LOW: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_16]
      !power_event_buffer_type_ff |=> !power_event_out) else $error("open drain high");
   AST_TX_FREE: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_04]
      tx_data_push_in && !tx_data_drain_in
      |=> tx_data_free_bytes_ff == $past(tx_data_free_bytes_ff) - `FLPC_DWORD_BYTES)
      else $error("free count wrong");
   AST_RX_STATUS: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_01]
      rx_status_push_in && !rx_status_pop_in
      |=> rx_status_used_dwords_ff == $past(rx_status_used_dwords_ff) + 8'h01)
      else $error("rx status count wrong");
   AST_PULSE_END: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_18]
      event_hold_ff && power_event_pulse_select_ff && !trigger && (wake_frame_enable_ff
      || energy_detect_enable_ff) && pulse_cnt_ff == 32'(PULSE_CYCLES - 1)
      |=> !event_hold_ff) else $error("pulse too long");
   AST_ED_IRQ: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_15]
      energy_detect_event_in && energy_detect_enable_ff |=> power_event_interrupt_out)
      else $error("energy detect interrupt missing");
   AST_OE_GATES_PIN: assert property (@(posedge clock_in) disable iff (!rst_n_in) // [RULE_19]
      !power_event_output_enable_ff && !power_event_buffer_type_ff |=> !power_event_oe_out)
      else $error("open drain pin driven without output enable");
endmodule
